/* File: dv/tsi_cmd_tb.sv */
// self-checking bench for the spacing and identification command block
// assumes the far-side model in tsi_far_model and the tsi_pkg constants
module tsi_cmd_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] LEVEL = 16'h5A3C; // arbitrary value
	typedef struct {
		logic [1:0]  code;
		int          cnt;
		int          from;
		int          to;
		logic [31:0] st;
		int          info;
	} tsi_case_t;
	logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, dataInByte;
	logic [31:0] pwdata, prdata, rd;
	logic        tapeStepReq, tapeDirRev, tapeItemDone, tapeItemIsMark;
	logic        tapeAtBot, busDisconnect, reselectReq, reselectAck;
	logic        dataInValid, dataInReady, lastErr;
	int          err_total = 0;
	int          compares = 0;
	int          discCnt = 0;
	int          seed = 32'h76CB;
	logic [7:0]  expQ[$];
	logic [7:0]  idBytes[7];
	tsi_case_t   cases[14];

	tsi_cmd #(.MICROCODE_LEVEL(LEVEL)) uut (
		.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .tapeStepReq(tapeStepReq),
		.tapeDirRev(tapeDirRev), .tapeItemDone(tapeItemDone),
		.tapeItemIsMark(tapeItemIsMark), .tapeAtBot(tapeAtBot),
		.busDisconnect(busDisconnect), .reselectReq(reselectReq),
		.reselectAck(reselectAck), .dataInValid(dataInValid),
		.dataInByte(dataInByte), .dataInReady(dataInReady));
	tsi_far_model far (
		.clk(clk), .sys_rst(sys_rst), .tapeStepReq(tapeStepReq),
		.tapeDirRev(tapeDirRev), .reselectReq(reselectReq),
		.tapeItemDone(tapeItemDone), .tapeItemIsMark(tapeItemIsMark),
		.tapeAtBot(tapeAtBot), .reselectAck(reselectAck),
		.dataInReady(dataInReady));

	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report;
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'h1 && n < 50);
		if (pready !== 1'h1)
		begin
			err_total++;
			final_report();
		end
		rd = prdata;
		lastErr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask

	task automatic run(input logic [31:0] lo, input logic [31:0] hi);
		int n;
		apb(1'h1, tsi_pkg::ADDR_CDB_LO, lo);
		apb(1'h1, tsi_pkg::ADDR_CDB_HI, hi);
		apb(1'h1, tsi_pkg::ADDR_CTRL, 32'h1 << tsi_pkg::CTRL_START);
		n = 0;
		do
		begin
			apb(1'h0, tsi_pkg::ADDR_STATUS, 32'h0);
			n++;
		end
		while ((rd[tsi_pkg::ST_DONE] !== 1'h1 || rd[tsi_pkg::ST_BUSY] !== 1'h0)
			&& n < 3000);
		if (rd[tsi_pkg::ST_DONE] !== 1'h1 || rd[tsi_pkg::ST_BUSY] !== 1'h0)
		begin
			err_total++;
			final_report();
		end
	endtask

	always @(posedge clk)
		if (busDisconnect === 1'h1)
			discCnt++;

	// oldest expected byte against each accepted byte
	always @(posedge clk)
		if (dataInValid === 1'h1 && dataInReady === 1'h1)
			chk({24'h0, dataInByte},
				expQ.size() > 0 ? {24'h0, expQ.pop_front()} : 32'hFFFF_FFFF);

	initial
	begin
		tsi_case_t   c;
		logic [23:0] cv;
		int          d0;
		int          a;
		int          allocs[5];
		sys_rst = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cases = '{'{2'h0, 3, 0, 3, 32'h002, 0}, '{2'h0, 20, 0, 11, 32'h506, 10},
			'{2'h0, -5, 15, 10, 32'h506, 1}, '{2'h0, -3, 3, 0, 32'h002, 0},
			'{2'h1, 2, 0, 21, 32'h002, 0}, '{2'h1, -10, 25, 0, 32'h606, 7},
			'{2'h2, 2, 0, 22, 32'h002, 0}, '{2'h2, 3, 0, 33, 32'h002, 0},
			'{2'h2, -2, 40, 31, 32'h002, 0}, '{2'h2, -3, 40, 30, 32'h002, 0},
			'{2'h0, 0, 5, 5, 32'h002, 0}, '{2'h1, 0, 5, 5, 32'h002, 0},
			'{2'h2, 0, 5, 5, 32'h002, 0}, '{2'h3, 5, 5, 5, 32'h056, 0}};
		idBytes = '{8'h01, 8'h80, 8'h01, 8'h00, 8'h02, LEVEL[15:8], LEVEL[7:0]};
		repeat (20) @(posedge clk);
		sys_rst <= 1'h0;
		@(posedge clk);
		foreach (cases[i])
		begin
			c = cases[i];
			far.pos = c.from;
			d0 = discCnt;
			cv = c.cnt[23:0];
			run({cv[15:8], cv[23:16], 6'h0, c.code, tsi_pkg::OP_SPACE},
				{24'h0, cv[7:0]});
			chk(rd & 32'h7F6, c.st);
			chk(far.pos, c.to);
			chk(discCnt - d0, 32'(c.cnt != 0 && c.code != 2'h3));
			if (c.st[tsi_pkg::ST_VALID])
			begin
				apb(1'h0, tsi_pkg::ADDR_INFO, 32'h0);
				chk(rd, c.info);
			end
		end
		allocs = '{0, 3, 7, 9, $random(seed) & 32'hFF};
		apb(1'h1, tsi_pkg::ADDR_CTRL, 32'h1 << tsi_pkg::CTRL_UA_SET);
		foreach (allocs[i])
		begin
			a = allocs[i];
			for (int k = 0; k < 7 && k < a; k++)
				expQ.push_back(idBytes[k]);
			run({16'h0, 8'h00, tsi_pkg::OP_INQUIRY}, {24'h0, a[7:0]});
			chk(rd & 32'h7F6, 32'h002);
			chk(expQ.size(), 0);
			chk(rd[tsi_pkg::ST_UA], 1'h1);
		end
		run({24'h0, 8'h13}, 32'h0);
		chk(rd & 32'h7F6, 32'h056);
		apb(1'h1, tsi_pkg::ADDR_CTRL, 32'h1 << tsi_pkg::CTRL_UA_CLR);
		apb(1'h0, tsi_pkg::ADDR_STATUS, 32'h0);
		chk(rd[tsi_pkg::ST_UA], 1'h0);
		apb(1'h0, 8'h14, 32'h0);
		chk(lastErr, 1'h1);
		chk(rd, 32'h0);
		final_report();
	end
endmodule // tsi_cmd_tb

/* File: dv/tsi_far_model.sv */
// far side: a tape drive stepping a fixed tape image, plus the initiator
// assumes tapeStepReq is held high while the tape must move
module tsi_far_model (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic tapeStepReq,
	input  wire logic tapeDirRev,
	input  wire logic reselectReq,
	output logic      tapeItemDone,
	output logic      tapeItemIsMark,
	output logic      tapeAtBot,
	output logic      reselectAck,
	output logic      dataInReady
);
	timeunit 1ns;
	timeprecision 1ps;
	// filemarks at 10, 20-21, 30-32; all else blocks
	localparam logic [63:0] MARKS = 64'h0000_0001_C030_0400;
	int          pos = 0;
	int          seed = 32'h76CB;
	logic [31:0] rnd;
	logic        fwd;
	logic        rev;
	// start of tape shows only after the last item report has gone
	assign tapeAtBot = (pos == 0) && !tapeItemDone;
	initial
	begin
		tapeItemDone = 1'h0;
		tapeItemIsMark = 1'h0;
		reselectAck = 1'h0;
		dataInReady = 1'h0;
	end
	always @(posedge clk)
	begin
		rnd = $random(seed);
		// stepping pace varies; one pulse per item
		fwd = !sys_rst && tapeStepReq && !tapeItemDone && rnd[0];
		rev = fwd && tapeDirRev && pos > 0;
		fwd = fwd && !tapeDirRev && pos < 63;
		tapeItemDone <= fwd || rev;
		if (rev)
		begin
			tapeItemIsMark <= MARKS[pos - 1];
			pos <= pos - 1;
		end
		else if (fwd)
		begin
			tapeItemIsMark <= MARKS[pos];
			pos <= pos + 1;
		end
		else
			tapeItemIsMark <= rnd[1];
		reselectAck <= reselectReq && !reselectAck && rnd[2];
		dataInReady <= rnd[3];
	end
endmodule // tsi_far_model

/* File: logic/tsi_cmd.sv */
// tape spacing and identification command engine behind APB
// assumes a drive that pulses one item report per block or mark passed
module tsi_cmd #(
	parameter int          CNT_W           = 24,
	parameter logic [15:0] MICROCODE_LEVEL = 16'h0100 // arbitrary value
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	output logic             tapeStepReq,
	output logic             tapeDirRev,
	input  wire logic        tapeItemDone,
	input  wire logic        tapeItemIsMark,
	input  wire logic        tapeAtBot,
	output logic             busDisconnect,
	output logic             reselectReq,
	input  wire logic        reselectAck,
	output logic             dataInValid,
	output logic      [7:0]  dataInByte,
	input  wire logic        dataInReady
);
	typedef enum logic [7:0] {
		S_IDLE   = 8'b00000001,
		S_DECODE = 8'b00000010,
		S_DISC   = 8'b00000100,
		S_MOVE   = 8'b00001000,
		S_RESEL  = 8'b00010000,
		S_INQLD  = 8'b00100000,
		S_INQOUT = 8'b01000000,
		S_DONE   = 8'b10000000
	} tsi_state_t;

	tsi_state_t        state_ff;
	logic [31:0]       cdbLo_ff;
	logic [15:0]       cdbHi_ff;
	logic [31:0]       info_ff;
	logic              done_ff;
	logic              check_ff;
	logic [3:0]        senseKey_ff;
	logic              fmark_ff;
	logic              eom_ff;
	logic              valid_ff;
	logic              unitAttn_ff;
	logic              disc_ff;
	logic              dirRev_ff;
	logic [1:0]        code_ff;
	logic [CNT_W-1:0]  mag_ff;
	logic [CNT_W-1:0]  passed_ff;
	logic [2:0]        inqIdx_ff;
	logic [2:0]        inqLen_ff;
	logic [31:0]       prdata_ff;
	logic [7:0]        romData;

	logic              wrAcc;
	logic              addrHit;
	logic              startReq;
	logic [7:0]        opCode;
	logic [1:0]        posCode;
	logic [CNT_W-1:0]  countRaw;
	logic [CNT_W-1:0]  countMag;
	logic [7:0]        allocLen;
	logic [CNT_W-1:0]  nxt_passed;
	logic              lastItem;

	assign opCode   = cdbLo_ff[7:0];
	assign posCode  = cdbLo_ff[9:8];
	assign countRaw = CNT_W'({cdbLo_ff[23:16], cdbLo_ff[31:24],
		cdbHi_ff[7:0]});
	assign countMag = countRaw[CNT_W-1] ? CNT_W'(-countRaw) : countRaw;
	assign allocLen = cdbHi_ff[7:0];
	assign wrAcc    = psel && penable && pwrite;
	assign addrHit  = paddr == tsi_pkg::ADDR_CDB_LO
		|| paddr == tsi_pkg::ADDR_CDB_HI
		|| paddr == tsi_pkg::ADDR_CTRL
		|| paddr == tsi_pkg::ADDR_STATUS
		|| paddr == tsi_pkg::ADDR_INFO;
	assign startReq = wrAcc && paddr == tsi_pkg::ADDR_CTRL
		&& pwdata[tsi_pkg::CTRL_START] && state_ff == S_IDLE;

	// zero-wait slave; read data latched in the setup cycle
	assign pready  = psel && penable;
	assign pslverr = psel && penable && !addrHit;
	assign prdata  = prdata_ff;

	assign tapeStepReq   = state_ff == S_MOVE;
	assign tapeDirRev    = dirRev_ff;
	assign busDisconnect = state_ff == S_DISC;
	assign reselectReq   = state_ff == S_RESEL;
	assign dataInValid   = state_ff == S_INQOUT;
	assign dataInByte    = romData;

	// run counter restarts on a block when seeking a mark run
	always_comb
	begin
		nxt_passed = CNT_W'(passed_ff + 1'b1);
		if (code_ff == tsi_pkg::CODE_SEQFM && !tapeItemIsMark)
			nxt_passed = '0;
		lastItem = nxt_passed == mag_ff;
		if (code_ff == tsi_pkg::CODE_BLOCKS && tapeItemIsMark)
			lastItem = 1'b0;
		if (code_ff == tsi_pkg::CODE_FMARKS && !tapeItemIsMark)
			lastItem = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			prdata_ff <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
		begin
			unique case (paddr)
				tsi_pkg::ADDR_CDB_LO: prdata_ff <= cdbLo_ff;
				tsi_pkg::ADDR_CDB_HI: prdata_ff <= {16'h0000, cdbHi_ff};
				tsi_pkg::ADDR_STATUS:
					prdata_ff <= {19'h00000, disc_ff, unitAttn_ff,
						valid_ff, eom_ff, fmark_ff, senseKey_ff,
						1'b0, check_ff, done_ff, state_ff != S_IDLE};
				tsi_pkg::ADDR_INFO:   prdata_ff <= info_ff;
				default:              prdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// command bytes writable only while idle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cdbLo_ff <= 32'h0000_0000;
			cdbHi_ff <= 16'h0000;
		end
		else if (wrAcc && state_ff == S_IDLE)
		begin
			if (paddr == tsi_pkg::ADDR_CDB_LO)
				cdbLo_ff <= pwdata;
			if (paddr == tsi_pkg::ADDR_CDB_HI)
				cdbHi_ff <= pwdata[15:0];
		end
	end

	// unit attention changes only by software or reset, never by identify
	// attention kept pending
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			unitAttn_ff <= 1'b0;
		else if (wrAcc && paddr == tsi_pkg::ADDR_CTRL)
		begin
			if (pwdata[tsi_pkg::CTRL_UA_SET])
				unitAttn_ff <= 1'b1;
			else if (pwdata[tsi_pkg::CTRL_UA_CLR])
				unitAttn_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_ff    <= S_IDLE;
			done_ff     <= 1'b0;
			check_ff    <= 1'b0;
			senseKey_ff <= tsi_pkg::KEY_NO_SENSE;
			fmark_ff    <= 1'b0;
			eom_ff      <= 1'b0;
			valid_ff    <= 1'b0;
			disc_ff     <= 1'b0;
			info_ff     <= 32'h0000_0000;
			dirRev_ff   <= 1'b0;
			code_ff     <= tsi_pkg::CODE_BLOCKS;
			mag_ff      <= '0;
			passed_ff   <= '0;
			inqIdx_ff   <= 3'h0;
			inqLen_ff   <= 3'h0;
		end
		else
		begin
			unique case (state_ff)
				S_IDLE:
				begin
					if (startReq)
					begin
						state_ff    <= S_DECODE;
						done_ff     <= 1'b0;
						check_ff    <= 1'b0;
						senseKey_ff <= tsi_pkg::KEY_NO_SENSE;
						fmark_ff    <= 1'b0;
						eom_ff      <= 1'b0;
						valid_ff    <= 1'b0;
						disc_ff     <= 1'b0;
						info_ff     <= 32'h0000_0000;
					end
				end
				S_DECODE:
				begin
					code_ff   <= posCode;
					mag_ff    <= countMag;
					passed_ff <= '0;
					inqIdx_ff <= 3'h0;
					inqLen_ff <= allocLen > tsi_pkg::INQ_TOTAL_LEN
						? 3'(tsi_pkg::INQ_TOTAL_LEN) : allocLen[2:0];
					dirRev_ff <= countRaw[CNT_W-1];
					if (opCode == tsi_pkg::OP_SPACE)
					begin
						if (posCode == tsi_pkg::CODE_EOD)
						begin
							check_ff    <= 1'b1;
							senseKey_ff <= tsi_pkg::KEY_ILLEGAL;
							state_ff    <= S_DONE;
						end
						else if (countMag == '0)
							state_ff <= S_DONE;
						else
							state_ff <= S_DISC;
					end
					else if (opCode == tsi_pkg::OP_INQUIRY)
						state_ff <= allocLen == 8'h00 ? S_DONE : S_INQLD;
					else
					begin
						check_ff    <= 1'b1;
						senseKey_ff <= tsi_pkg::KEY_ILLEGAL;
						state_ff    <= S_DONE;
					end
				end
				S_DISC:
				begin
					disc_ff  <= 1'b1;
					state_ff <= S_MOVE;
				end
				S_MOVE:
				begin
					if (dirRev_ff && tapeAtBot)
					begin
						check_ff    <= 1'b1;
						eom_ff      <= 1'b1;
						valid_ff    <= 1'b1;
						senseKey_ff <= tsi_pkg::KEY_NO_SENSE;
						info_ff     <= 32'(mag_ff - passed_ff);
						state_ff    <= S_RESEL;
					end
					else if (tapeItemDone)
					begin
						if (code_ff == tsi_pkg::CODE_BLOCKS
							&& tapeItemIsMark)
						begin
							check_ff    <= 1'b1;
							fmark_ff    <= 1'b1;
							valid_ff    <= 1'b1;
							senseKey_ff <= tsi_pkg::KEY_NO_SENSE;
							info_ff     <= 32'(mag_ff - passed_ff);
							state_ff    <= S_RESEL;
						end
						else if (lastItem)
						begin
							passed_ff <= nxt_passed;
							state_ff  <= S_RESEL;
						end
						else if (code_ff != tsi_pkg::CODE_FMARKS
							|| tapeItemIsMark)
							passed_ff <= nxt_passed;
					end
				end
				S_RESEL:
				begin
					if (reselectAck)
					begin
						disc_ff  <= 1'b0;
						state_ff <= S_DONE;
					end
				end
				S_INQLD:
					state_ff <= S_INQOUT;
				S_INQOUT:
				begin
					if (dataInReady)
					begin
						inqIdx_ff <= 3'(inqIdx_ff + 1'b1);
						if (3'(inqIdx_ff + 1'b1) == inqLen_ff)
							state_ff <= S_DONE;
						else
							state_ff <= S_INQLD;
					end
				end
				S_DONE:
				begin
					done_ff  <= 1'b1;
					state_ff <= S_IDLE;
				end
				default:
					state_ff <= S_IDLE;
			endcase
		end
	end

	// extra length fixed in the store
	tsi_inq_rom #(
		.MICROCODE_LEVEL (MICROCODE_LEVEL)
	) uInqRom (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.rdIdx     (inqIdx_ff),
		.rdData_ff (romData)
	);

	illegal_code_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_ff == S_DECODE && opCode == tsi_pkg::OP_SPACE
		&& posCode == tsi_pkg::CODE_EOD
		|=> check_ff && senseKey_ff == tsi_pkg::KEY_ILLEGAL ##1 !tapeStepReq)
		else $error("end-of-data code not rejected");

	zero_count_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_ff == S_DECODE && opCode == tsi_pkg::OP_SPACE
		&& posCode != tsi_pkg::CODE_EOD && countMag == '0
		|=> !tapeStepReq && !busDisconnect ##1 done_ff && !check_ff)
		else $error("zero count moved tape");

	disc_first_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_ff == S_DECODE && opCode == tsi_pkg::OP_SPACE
		&& posCode != tsi_pkg::CODE_EOD && countMag != '0
		|=> busDisconnect ##1 tapeStepReq)
		else $error("no disconnect before motion");

	move_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
		tapeStepReq |-> tapeDirRev == countRaw[CNT_W-1])
		else $error("motion direction does not follow count sign");

	mark_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
		tapeStepReq && !(tapeDirRev && tapeAtBot) && tapeItemDone
		&& tapeItemIsMark && code_ff == tsi_pkg::CODE_BLOCKS
		|=> !tapeStepReq && fmark_ff && valid_ff && check_ff
		&& info_ff == 32'($past(mag_ff) - $past(passed_ff)))
		else $error("filemark did not stop block spacing");

	bot_stop_a: assert property (@(posedge clk) disable iff (sys_rst)
		tapeStepReq && tapeDirRev && tapeAtBot
		|=> reselectReq && eom_ff && valid_ff && check_ff)
		else $error("start of tape not reported");

	count_done_a: assert property (@(posedge clk) disable iff (sys_rst)
		tapeStepReq && !(tapeDirRev && tapeAtBot) && tapeItemDone
		&& lastItem |=> !tapeStepReq && passed_ff == mag_ff && !check_ff)
		else $error("spacing did not end after N items");

	inq_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
		state_ff == S_DECODE && opCode == tsi_pkg::OP_INQUIRY
		&& allocLen == 8'h00 |=> !dataInValid ##1 done_ff && !check_ff)
		else $error("zero length identify misbehaved");

	inq_len_a: assert property (@(posedge clk) disable iff (sys_rst)
		dataInValid && dataInReady && 3'(inqIdx_ff + 1'b1) == inqLen_ff
		|=> !dataInValid ##1 done_ff)
		else $error("identify sent wrong byte count");

	ua_kept_a: assert property (@(posedge clk) disable iff (sys_rst)
		dataInValid && !wrAcc |=> unitAttn_ff == $past(unitAttn_ff))
		else $error("identify changed unit attention");
endmodule // tsi_cmd

/* File: logic/tsi_inq_rom.sv */
// identification block store with registered read data
// assumes the reader waits one cycle after presenting an index
module tsi_inq_rom #(
	parameter logic [15:0] MICROCODE_LEVEL = 16'h0100 // arbitrary value
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [2:0] rdIdx,
	output logic      [7:0] rdData_ff
);
	logic [7:0] nxt_rdData;

	always_comb
	begin
		unique case (rdIdx)
			tsi_pkg::IDX_TYPE: nxt_rdData = tsi_pkg::INQ_DEV_TYPE;
			tsi_pkg::IDX_RMB:  nxt_rdData = tsi_pkg::INQ_RMB_BYTE;
			tsi_pkg::IDX_VER:  nxt_rdData = tsi_pkg::INQ_VERSION;
			tsi_pkg::IDX_RSV:  nxt_rdData = tsi_pkg::INQ_RESERVED;
			tsi_pkg::IDX_ADD:  nxt_rdData = tsi_pkg::INQ_ADD_LEN;
			tsi_pkg::IDX_MCH:  nxt_rdData = MICROCODE_LEVEL[15:8];
			tsi_pkg::IDX_MCL:  nxt_rdData = MICROCODE_LEVEL[7:0];
			default:           nxt_rdData = tsi_pkg::INQ_RESERVED;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			rdData_ff <= 8'h00;
		else
			rdData_ff <= nxt_rdData;
	end
endmodule // tsi_inq_rom

/* File: logic/tsi_pkg.sv */
// constants for the tape spacing / identification command block
// assumes an APB master with 32-bit data and one 250 MHz clock
package tsi_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CDB_LO = 8'h00;
	localparam logic [7:0] ADDR_CDB_HI = 8'h04;
	localparam logic [7:0] ADDR_CTRL   = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_INFO   = 8'h10;
	// control bits
	localparam int CTRL_START  = 0;
	localparam int CTRL_UA_SET = 1;
	localparam int CTRL_UA_CLR = 2;
	// status bits
	localparam int ST_BUSY   = 0;
	localparam int ST_DONE   = 1;
	localparam int ST_CHECK  = 2;
	localparam int ST_KEY_LO = 4;
	localparam int ST_FMARK  = 8;
	localparam int ST_EOM    = 9;
	localparam int ST_VALID  = 10;
	localparam int ST_UA     = 11;
	localparam int ST_DISC   = 12;
	// operation codes
	localparam logic [7:0] OP_SPACE   = 8'h11;
	localparam logic [7:0] OP_INQUIRY = 8'h12;
	// positioning codes
	localparam logic [1:0] CODE_BLOCKS = 2'h0;
	localparam logic [1:0] CODE_FMARKS = 2'h1;
	localparam logic [1:0] CODE_SEQFM  = 2'h2;
	localparam logic [1:0] CODE_EOD    = 2'h3;
	// sense keys
	localparam logic [3:0] KEY_NO_SENSE = 4'h0;
	localparam logic [3:0] KEY_ILLEGAL  = 4'h5;
	// identification block
	localparam logic [7:0] INQ_DEV_TYPE  = 8'h01;
	localparam logic [7:0] INQ_RMB_BYTE  = 8'h80;
	localparam logic [7:0] INQ_VERSION   = 8'h01;
	localparam logic [7:0] INQ_RESERVED  = 8'h00;
	localparam logic [7:0] INQ_ADD_LEN   = 8'h02;
	localparam logic [7:0] INQ_TOTAL_LEN = 8'h07;
	// byte indexes in the identification block
	localparam logic [2:0] IDX_TYPE = 3'h0;
	localparam logic [2:0] IDX_RMB  = 3'h1;
	localparam logic [2:0] IDX_VER  = 3'h2;
	localparam logic [2:0] IDX_RSV  = 3'h3;
	localparam logic [2:0] IDX_ADD  = 3'h4;
	localparam logic [2:0] IDX_MCH  = 3'h5;
	localparam logic [2:0] IDX_MCL  = 3'h6;
endpackage
